// >>> hw/cfr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cfr_regs #(
  parameter int FB_W = cfr_pkg::FB_W,
  parameter int NUM_OUT = cfr_pkg::NUM_OUT,
  parameter int SAMPLE_CYC = cfr_pkg::SAMPLE_CYC,
  parameter logic [9:0] DIE_X = 10'h000, // Arbitrary value
  parameter logic [9:0] DIE_Y = 10'h000, // Arbitrary value
  parameter logic [9:0] WAFER = 10'h000 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Regulation loop values, one per output
  input wire logic [NUM_OUT*FB_W-1:0] loop_value_in,
  // Logic supply regulator below falling undervoltage threshold
  input wire logic logic_supply_uv_in,
  // Register read request from the serial interface
  input wire cfr_pkg::cfr_req_type req_in,
  // Read data (parity slot bit 0 left zero) and valid
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // Status byte fault bit
  output logic global_fault_bit_two_out
);
  // Width of the sampling timer
  localparam int SAMPLE_CNT_W = cfr_pkg::SAMPLE_CNT_W;

  typedef struct packed {
    logic [SAMPLE_CNT_W-1:0] cnt;
    logic sample;
    logic uv_flag;
    logic [15:0] rdata;
    logic rvalid;
  } cfr_state_type;

  cfr_state_type s_r, s_nxt;
  logic [NUM_OUT*FB_W-1:0] filt;

  // Word layout for a 10-bit field above the parity slot
  function automatic logic [15:0] place10(input logic [9:0] v);
    place10 = 16'h0000;
    place10[cfr_pkg::FB_LSB +: cfr_pkg::FB_W] = v;
  endfunction

  // One sampler per output
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_ch
    cfr_filter #(.W(FB_W), .SHIFT(cfr_pkg::FILT_SHIFT)) u_filt (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .sample_in(s_r.sample),
      .raw_in(loop_value_in[i*FB_W +: FB_W]),
      .value_out(filt[i*FB_W +: FB_W])
    );
  end

  // Sampling timer, flag and read decode
  always_comb begin
    int idx;
    idx = 0;
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.sample = 1'b0;
    if (s_r.cnt == SAMPLE_CNT_W'(SAMPLE_CYC - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.sample = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + SAMPLE_CNT_W'(1);
    end
    if (req_in.valid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = 16'h0000;
      if (req_in.addr >= cfr_pkg::ADDR_FB_FIRST && req_in.addr <= cfr_pkg::ADDR_FB_LAST) begin
        idx = int'(req_in.addr - cfr_pkg::ADDR_FB_FIRST);
        s_nxt.rdata = place10(filt[idx*FB_W +: FB_W]);
        if (req_in.addr == cfr_pkg::ADDR_FB_FIRST) begin
          s_nxt.rdata[cfr_pkg::UV_BIT] = s_r.uv_flag;
          if (req_in.clear) begin
            s_nxt.uv_flag = 1'b0;
          end
        end
      end else if (req_in.addr == cfr_pkg::ADDR_DIE_X) begin
        s_nxt.rdata = place10(DIE_X);
      end else if (req_in.addr == cfr_pkg::ADDR_DIE_Y) begin
        s_nxt.rdata = place10(DIE_Y);
      end else if (req_in.addr == cfr_pkg::ADDR_WAFER) begin
        s_nxt.rdata = place10(WAFER);
      end
    end
    // Set wins over clear
    if (logic_supply_uv_in) begin
      s_nxt.uv_flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rdata;
  assign rvalid_out = s_r.rvalid;
  assign global_fault_bit_two_out = s_r.uv_flag;

  // Checks
  a_uv_sets: assert property (@(posedge clk_in) disable iff (!nrst_in)
    logic_supply_uv_in |=> s_r.uv_flag) else $error("uv flag not set");
  a_uv_holds: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_r.uv_flag && !(req_in.valid && req_in.clear && req_in.addr == cfr_pkg::ADDR_FB_FIRST)
    |=> s_r.uv_flag) else $error("uv flag lost");
  a_fault_mirror: assert property (@(posedge clk_in) disable iff (!nrst_in)
    global_fault_bit_two_out == s_r.uv_flag) else $error("fault bit mismatch");
  a_read_answer: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid |=> rvalid_out) else $error("no read answer");
  a_fb_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rvalid_out |-> rdata_out[14:11] == 4'h0 && rdata_out[0] == 1'b0)
    else $error("reserved bits set");
  a_sample_period: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_r.sample |=> !s_r.sample) else $error("sampling every cycle");
  a_trace_x: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr == cfr_pkg::ADDR_DIE_X |=> rdata_out == place10(DIE_X))
    else $error("die x wrong");
  a_spare_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr == cfr_pkg::ADDR_SPARE |=> rdata_out == 16'h0000)
    else $error("spare not zero");

  // Strobe only fires on the timer wrap
  a_sample_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_r.sample |-> s_r.cnt == '0) else $error("strobe off the wrap");

  // Timer end always yields a strobe
  a_sample_due: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_r.cnt == SAMPLE_CNT_W'(SAMPLE_CYC - 1) |=> s_r.sample)
    else $error("strobe missing");

  // Filtered values stay put between strobes
  a_filter_still: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !s_r.sample |=> $stable(filt)) else $error("filter moved without strobe");

  // First channel read returns the filtered value
  a_fb_value: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr == cfr_pkg::ADDR_FB_FIRST
    |=> rdata_out[cfr_pkg::FB_LSB +: FB_W] == $past(filt[FB_W-1:0]))
    else $error("feedback word wrong");

  // Read-and-clear drops the flag when no new event
  a_uv_clears: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.clear && req_in.addr == cfr_pkg::ADDR_FB_FIRST
    && !logic_supply_uv_in |=> !s_r.uv_flag) else $error("uv flag not cleared");

  // New event beats a clear in the same cycle
  a_uv_set_wins: assert property (@(posedge clk_in) disable iff (!nrst_in)
    logic_supply_uv_in && req_in.valid && req_in.clear |=> s_r.uv_flag)
    else $error("clear beat set");

  // Flag bit appears only in the first channel word
  a_uv_bit_only: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr != cfr_pkg::ADDR_FB_FIRST
    |=> !rdata_out[cfr_pkg::UV_BIT]) else $error("flag bit leaked");

  // Fault bit follows a new event
  a_fault_rises: assert property (@(posedge clk_in) disable iff (!nrst_in)
    logic_supply_uv_in |=> global_fault_bit_two_out) else $error("fault bit late");

  // Answer is a single-cycle pulse
  a_rvalid_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !req_in.valid |=> !rvalid_out) else $error("stray answer");

  // Read word holds while idle
  a_rdata_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !req_in.valid |=> $stable(rdata_out)) else $error("read word moved");

  // Identity words for Y and wafer
  a_trace_y: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr == cfr_pkg::ADDR_DIE_Y |=> rdata_out == place10(DIE_Y))
    else $error("die y wrong");
  a_trace_wafer: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr == cfr_pkg::ADDR_WAFER |=> rdata_out == place10(WAFER))
    else $error("wafer word wrong");

  // Unmapped addresses read as zero
  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.addr > cfr_pkg::ADDR_SPARE |=> rdata_out == 16'h0000)
    else $error("unmapped not zero");

  // Scenario coverage
  c_uv_clear: cover property (@(posedge clk_in) s_r.uv_flag ##1 !s_r.uv_flag);
  c_trace_read: cover property (@(posedge clk_in) req_in.valid && req_in.addr == cfr_pkg::ADDR_WAFER);
  c_fb_read: cover property (@(posedge clk_in) req_in.valid && req_in.addr == cfr_pkg::ADDR_FB_LAST);
  c_sample: cover property (@(posedge clk_in) s_r.sample);
endmodule // cfr_regs
`default_nettype wire

// >>> hw/cfr_pkg.sv
package cfr_pkg;
  // Register addresses (6-bit register address field)
  localparam logic [5:0] ADDR_FB_FIRST = 6'h13;
  localparam logic [5:0] ADDR_FB_LAST = 6'h18;
  localparam logic [5:0] ADDR_DIE_X = 6'h19;
  localparam logic [5:0] ADDR_DIE_Y = 6'h1a;
  localparam logic [5:0] ADDR_WAFER = 6'h1b;
  localparam logic [5:0] ADDR_SPARE = 6'h1c;
  // Field layout
  localparam int FB_W = 10;
  localparam int FB_LSB = 1;
  localparam int UV_BIT = 15;
  localparam int TRACE_W = 10;
  localparam int TRACE_LSB = 1;
  localparam int NUM_OUT = 6;
  // Reset values
  localparam logic [9:0] FB_RST = 10'h000;
  // Sample period and filter shift
  localparam int SAMPLE_NS = 1000;
  localparam int CLK_NS = 4;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CNT_W = 8;
  localparam int FILT_SHIFT = 2;

  // Register read request
  typedef struct packed {
    logic valid;
    logic clear;
    logic [5:0] addr;
  } cfr_req_type;
endpackage

// >>> hw/cfr_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Periodic sampler with first-order low-pass filter for one feedback channel
module cfr_filter #(
  parameter int W = 10,
  parameter int SHIFT = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Sample strobe and raw loop value
  input wire logic sample_in,
  input wire logic [W-1:0] raw_in,
  // Filtered value
  output logic [W-1:0] value_out
);
  typedef struct packed {
    logic [W+SHIFT-1:0] acc;
  } cfr_filt_state_type;

  cfr_filt_state_type s_r, s_nxt;

  // Accumulator moves a fraction toward the sample, only on the strobe
  always_comb begin
    s_nxt = s_r;
    if (sample_in) begin
      s_nxt.acc = s_r.acc - (W+SHIFT)'(s_r.acc >> SHIFT) + (W+SHIFT)'(raw_in);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign value_out = s_r.acc[W+SHIFT-1:SHIFT];
endmodule // cfr_filter
`default_nettype wire

// >>> tb/cfr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host reader: issues register reads and scales feedback
module cfr_host (
  // Clock
  input wire logic clk_in,
  // Read request and answer
  output var cfr_pkg::cfr_req_type req_out,
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in
);
  initial req_out = '0;
  // One read; a missing answer comes back unknown
  task automatic rd(input logic [5:0] a, input logic c, output logic [15:0] d);
    @(posedge clk_in);
    req_out <= '{valid: 1'b1, clear: c, addr: a};
    @(posedge clk_in);
    req_out <= '0;
    #1;
    d = rvalid_in ? rdata_in : 16'hxxxx;
  endtask
  // Feedback in microamps: drop flag and parity, 6250 uA per count
  function automatic int ua(input logic [15:0] w);
    return int'((w & 16'h7fff) >> 1) * 6250;
  endfunction
endmodule // cfr_host
`default_nettype wire

// >>> tb/cfr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module cfr_regs_test;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [59:0] loop_value = '0;
  logic uv = 1'b0;
  cfr_pkg::cfr_req_type req;
  logic [15:0] rdata;
  logic rvalid;
  logic fe2;
  logic [15:0] d;
  logic [9:0] e;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  // Clock generator
  initial forever #2 clk_in = ~clk_in;
  cfr_regs #(.SAMPLE_CYC(4), .DIE_X(10'h2a5), .DIE_Y(10'h13c), .WAFER(10'h0f1)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .loop_value_in(loop_value),
    .logic_supply_uv_in(uv), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
    .global_fault_bit_two_out(fe2));
  cfr_host u_host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
  // Compare one word
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  // Verdict
  task automatic wrap_up;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Reset values, identity words, spare and unmapped
  task automatic t_reset;
    for (int a = 'h13; a <= 'h1d; a++) begin
      e = (a == 'h19) ? 10'h2a5 : (a == 'h1a) ? 10'h13c : (a == 'h1b) ? 10'h0f1 : 10'h000;
      u_host.rd(6'(a == 'h1d ? 'h3f : a), 1'b0, d);
      chk("idle word", {5'h00, e, 1'b0}, d);
    end
    $display("t_reset done");
  endtask
  // Filtered feedback for all six outputs
  task automatic t_feedback;
    @(posedge clk_in);
    for (int i = 0; i < 6; i++) loop_value[i*10+:10] <= 10'(i * 'h55 + 'h40);
    u_host.rd(6'h13, 1'b0, d);
    chk("fb early", 16'h0001, 16'(d[10:1] < 10'h040));
    repeat (600) @(posedge clk_in);
    for (int i = 0; i < 6; i++) begin
      u_host.rd(6'(6'h13 + i), 1'b0, d);
      chk("fb settled", {5'h00, 10'(i * 'h55 + 'h40), 1'b0}, d);
      chk("fb scaled", 16'(i * 'h55 + 'h40), 16'(u_host.ua(d) / 6250));
      chk("fb spare", 16'h0000, {d[15:11], d[0]});
    end
    $display("t_feedback done");
  endtask
  // Latched undervoltage and read-and-clear
  task automatic t_uv;
    @(posedge clk_in) loop_value <= '0;
    uv <= 1'b1;
    @(posedge clk_in) uv <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("fault bit", 16'h0001, {15'h0, fe2});
    u_host.rd(6'h14, 1'b1, d);
    u_host.rd(6'h13, 1'b0, d);
    chk("uv kept", 16'h0001, {15'h0, d[15]});
    u_host.rd(6'h13, 1'b1, d);
    chk("uv read", 16'h0001, {15'h0, d[15]});
    u_host.rd(6'h13, 1'b0, d);
    chk("uv cleared", 16'h0000, {15'h0, d[15]});
    chk("fault off", 16'h0000, {15'h0, fe2});
    $display("t_uv done");
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_feedback();
    t_uv();
    wrap_up();
  end
endmodule // cfr_regs_test
`default_nettype wire
